// ==== include/dsff_pkg.sv ====
package dsff_pkg;

	localparam int SEL_W = 4;
	localparam int RES_W = 16;
	localparam int CONV_W = 14;
	localparam int RES_LSB = 2;
	localparam int SCAN_W = 3;

	// diagnostic selector codes
	localparam logic [3:0] SEL_NONE = 4'h0;
	localparam logic [3:0] SEL_ABS_TEMP = 4'h1;
	localparam logic [3:0] SEL_ANALOG_SUPPLY = 4'h2;
	localparam logic [3:0] SEL_ALT_REF = 4'h3;
	localparam logic [3:0] SEL_COMP_PATH = 4'h4;
	localparam logic [3:0] SEL_GAIN_CAL = 4'h5;
	localparam logic [3:0] SEL_OFFSET_CAL = 4'h6;
	localparam logic [3:0] SEL_DAC_HIGH = 4'h7;
	localparam logic [3:0] SEL_DAC_LOW = 4'h8;
	localparam logic [3:0] SEL_THERM_CAL = 4'h9;
	localparam logic [3:0] SEL_ZERO_SCALE = 4'ha;
	localparam logic [3:0] SEL_FULL_SCALE = 4'hb;
	localparam logic [3:0] SEL_LS_AMP = 4'hc;
	localparam logic [3:0] SEL_COMM_RAIL = 4'hd;

	// balancing-switch scan configuration codes
	localparam logic [2:0] SCAN_SW_SHORT = 3'h4;
	localparam logic [2:0] SCAN_SW_OPEN = 3'h5;
	localparam logic [2:0] SCAN_ODD_WIRE = 3'h6;
	localparam logic [2:0] SCAN_EVEN_WIRE = 3'h7;

	// DAC drive codes for the stuck-bit checks
	localparam logic [13:0] DAC_ZERO = 14'h0000;
	localparam logic [13:0] DAC_QUARTER = 14'h1000;
	localparam logic [13:0] DAC_THREE_QTR = 14'h3000;

	localparam logic [15:0] RESULT_RST = 16'h0000;

	// slow oscillator check
	localparam int CORE_CLK_HZ = 200_000_000;
	localparam int SLOW_OSC_HZ = 32_768;
	localparam int OSC_PERIODS = 2;
	localparam int OSC_TOL_PCT = 5;
	localparam int OSC_EXPECT = CORE_CLK_HZ / SLOW_OSC_HZ * OSC_PERIODS;

endpackage

// ==== verilog/dsff_osc_check.sv ====
`timescale 1ns/1ps
module dsff_osc_check #(
	parameter int EXPECT_CNT = dsff_pkg::OSC_EXPECT,
	parameter int CNT_W = 16
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic slow_osc_tick,
	output logic osc_fault
);

	localparam int TOL = EXPECT_CNT * dsff_pkg::OSC_TOL_PCT / 100;
	localparam logic [CNT_W-1:0] HI_LIM = CNT_W'(EXPECT_CNT + TOL);
	localparam logic [CNT_W-1:0] LO_LIM = CNT_W'(EXPECT_CNT - TOL);

	if (EXPECT_CNT + TOL >= (1 << CNT_W) || EXPECT_CNT < 20) begin : g_bad_cnt
		$error("dsff_osc_check: bad count parameters");
	end

	logic [CNT_W-1:0] cnt_r;
	logic half_r;
	logic armed_r;
	logic sample;

	assign sample = slow_osc_tick && half_r;

	// fast-clock counter over two slow periods
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= '0;
		end else if (sample) begin
			cnt_r <= '0;
		end else if (cnt_r != '1) begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			half_r <= 1'b0;
			armed_r <= 1'b0;
		end else if (slow_osc_tick) begin
			half_r <= ~half_r;
			if (half_r)
				armed_r <= 1'b1;
		end
	end

	// first window after reset is partial, so it is not judged
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			osc_fault <= 1'b0;
		end else begin
			osc_fault <= sample && armed_r && (cnt_r > HI_LIM || cnt_r < LO_LIM);
		end
	end

endmodule

// ==== verilog/dsff_diag_ctl.sv ====
`timescale 1ns/1ps
module dsff_diag_ctl #(
	parameter int N_SWITCH = 14,
	parameter int OSC_EXPECT_CNT = dsff_pkg::OSC_EXPECT
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [3:0] diag_select_a,
	input wire logic [3:0] diag_select_b,
	input wire logic acq_start,
	input wire logic acq_done,
	input wire logic oversample_en,
	output logic conv_req,
	output logic [3:0] conv_source,
	output logic conv_ref_analog,
	output logic conv_force_zero,
	output logic conv_force_full,
	output logic dac_drive_en,
	output logic [13:0] dac_drive_code,
	output logic thermistor_bias_en,
	output logic temp_monitor_hold,
	input wire logic conv_done,
	input wire logic [13:0] conv_data,
	output logic [15:0] diag_result_a,
	output logic [15:0] diag_result_b,
	output logic diag_busy,
	input wire logic [2:0] scan_config,
	input wire logic scan_done,
	input wire logic [N_SWITCH-1:0] switch_fault,
	output logic [N_SWITCH-1:0] balance_switch_alert,
	output logic balance_switch_alert_summary,
	input wire logic acc_over_cmp,
	input wire logic acc_under_cmp,
	output logic accuracy_over_alert,
	output logic accuracy_under_alert,
	input wire logic measuring,
	input wire logic headroom_low_cmp,
	output logic pump_headroom_alert,
	input wire logic flex_pack_en,
	input wire logic flex_fault_det,
	output logic flex_pack_fault_alert,
	input wire logic rx_upper_fault,
	input wire logic rx_lower_fault,
	output logic rx_upper_mode_alert,
	output logic rx_lower_mode_alert,
	input wire logic slow_osc_tick,
	output logic slow_osc_alert_a,
	output logic slow_osc_alert_b,
	input wire logic alert_clear
);

	if (N_SWITCH < 1 || N_SWITCH > 16) begin : g_bad_width
		$error("dsff_diag_ctl: N_SWITCH out of range");
	end

	typedef enum logic [2:0] {
		DSFF_IDLE,
		DSFF_CONV_A,
		DSFF_CONV_B,
		DSFF_WAIT_END
	} dsff_state_t;

	dsff_state_t state_r;
	dsff_state_t state_nxt;
	logic [3:0] sel_a_r;
	logic [3:0] sel_b_r;
	logic [3:0] cur_sel;
	logic por_check_r;
	logic osc_fault;

	// selector codes that start a measurement
	function automatic logic is_assigned(input logic [3:0] code);
		unique case (code)
			dsff_pkg::SEL_ABS_TEMP,
			dsff_pkg::SEL_ANALOG_SUPPLY,
			dsff_pkg::SEL_ALT_REF,
			dsff_pkg::SEL_COMP_PATH,
			dsff_pkg::SEL_GAIN_CAL,
			dsff_pkg::SEL_OFFSET_CAL,
			dsff_pkg::SEL_DAC_HIGH,
			dsff_pkg::SEL_DAC_LOW,
			dsff_pkg::SEL_THERM_CAL,
			dsff_pkg::SEL_ZERO_SCALE,
			dsff_pkg::SEL_FULL_SCALE,
			dsff_pkg::SEL_LS_AMP,
			dsff_pkg::SEL_COMM_RAIL: is_assigned = 1'b1;
			default: is_assigned = 1'b0;
		endcase
	endfunction

	// left-justified result word
	function automatic logic [15:0] justify(input logic [13:0] d);
		justify = {d, 2'b00};
	endfunction

	// selectors latched at acquisition start
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			sel_a_r <= dsff_pkg::SEL_NONE;
			sel_b_r <= dsff_pkg::SEL_NONE;
		end else if (state_r == DSFF_IDLE && acq_start) begin
			sel_a_r <= diag_select_a;
			sel_b_r <= diag_select_b;
		end
	end

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			DSFF_IDLE: begin
				if (acq_start) begin
					if (is_assigned(diag_select_a))
						state_nxt = DSFF_CONV_A;
					else if (is_assigned(diag_select_b))
						state_nxt = DSFF_CONV_B;
					else
						state_nxt = DSFF_WAIT_END;
				end
			end
			DSFF_CONV_A: begin
				if (conv_done) begin
					if (is_assigned(sel_b_r))
						state_nxt = DSFF_CONV_B;
					else
						state_nxt = DSFF_WAIT_END;
				end
			end
			DSFF_CONV_B: begin
				if (conv_done)
					state_nxt = DSFF_WAIT_END;
			end
			DSFF_WAIT_END: begin
				if (acq_done)
					state_nxt = DSFF_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			state_r <= DSFF_IDLE;
		else
			state_r <= state_nxt;
	end

	// source routing for the active selector
	assign cur_sel = (state_r == DSFF_CONV_B) ? sel_b_r : sel_a_r;
	assign conv_req = (state_r == DSFF_CONV_A) || (state_r == DSFF_CONV_B);
	assign diag_busy = (state_r != DSFF_IDLE);
	assign conv_source = conv_req ? cur_sel : dsff_pkg::SEL_NONE;
	assign conv_ref_analog = conv_req
		&& cur_sel == dsff_pkg::SEL_ANALOG_SUPPLY;
	assign conv_force_zero = conv_req
		&& cur_sel == dsff_pkg::SEL_ZERO_SCALE;
	assign conv_force_full = conv_req
		&& cur_sel == dsff_pkg::SEL_FULL_SCALE;
	assign thermistor_bias_en = conv_req
		&& cur_sel == dsff_pkg::SEL_THERM_CAL;
	assign temp_monitor_hold = diag_busy
		&& (sel_a_r == dsff_pkg::SEL_ABS_TEMP
		|| sel_b_r == dsff_pkg::SEL_ABS_TEMP);

	// DAC levels for the stuck-bit checks
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			dac_drive_en <= 1'b0;
			dac_drive_code <= dsff_pkg::DAC_ZERO;
		end else if (state_nxt == DSFF_CONV_A || state_nxt == DSFF_CONV_B) begin
			if (state_nxt == DSFF_CONV_A && state_r == DSFF_IDLE) begin
				dac_drive_en <= diag_select_a == dsff_pkg::SEL_DAC_HIGH
					|| diag_select_a == dsff_pkg::SEL_DAC_LOW;
				dac_drive_code <= diag_select_a == dsff_pkg::SEL_DAC_HIGH ?
					dsff_pkg::DAC_THREE_QTR : dsff_pkg::DAC_QUARTER;
			end else if (state_nxt == DSFF_CONV_B && state_r != DSFF_CONV_B) begin
				dac_drive_en <= (state_r == DSFF_IDLE ? diag_select_b : sel_b_r)
					== dsff_pkg::SEL_DAC_HIGH
					|| (state_r == DSFF_IDLE ? diag_select_b : sel_b_r)
					== dsff_pkg::SEL_DAC_LOW;
				dac_drive_code <= (state_r == DSFF_IDLE ? diag_select_b : sel_b_r)
					== dsff_pkg::SEL_DAC_HIGH ?
					dsff_pkg::DAC_THREE_QTR : dsff_pkg::DAC_QUARTER;
			end
		end else begin
			dac_drive_en <= 1'b0;
			dac_drive_code <= dsff_pkg::DAC_ZERO;
		end
	end

	// per-selector result registers
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			diag_result_a <= dsff_pkg::RESULT_RST;
		else if (state_r == DSFF_CONV_A && conv_done)
			diag_result_a <= justify(conv_data);
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			diag_result_b <= dsff_pkg::RESULT_RST;
		else if (state_r == DSFF_CONV_B && conv_done)
			diag_result_b <= justify(conv_data);
	end

	// balancing-switch diagnostic scans
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			balance_switch_alert <= '0;
			balance_switch_alert_summary <= 1'b0;
		end else if (scan_done && scan_config[2]) begin
			balance_switch_alert <= balance_switch_alert | switch_fault;
			balance_switch_alert_summary <= balance_switch_alert_summary
				|| (|switch_fault);
		end else if (alert_clear) begin
			balance_switch_alert <= '0;
			balance_switch_alert_summary <= 1'b0;
		end
	end

	// accuracy comparison after oversampled acquisitions
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			accuracy_over_alert <= 1'b0;
			accuracy_under_alert <= 1'b0;
		end else if (acq_done && oversample_en) begin
			accuracy_over_alert <= acc_over_cmp;
			accuracy_under_alert <= acc_under_cmp;
		end
	end

	// headroom refreshed while measuring only
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			pump_headroom_alert <= 1'b0;
		else if (measuring)
			pump_headroom_alert <= headroom_low_cmp;
	end

	// flexible-pack fault, sticky, set beats clear
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			flex_pack_fault_alert <= 1'b0;
		else if (flex_pack_en && flex_fault_det)
			flex_pack_fault_alert <= 1'b1;
		else if (alert_clear)
			flex_pack_fault_alert <= 1'b0;
	end

	// receive pin mode check once after reset release
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			por_check_r <= 1'b1;
		else
			por_check_r <= 1'b0;
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_upper_mode_alert <= 1'b0;
			rx_lower_mode_alert <= 1'b0;
		end else if (por_check_r) begin
			rx_upper_mode_alert <= rx_upper_fault;
			rx_lower_mode_alert <= rx_lower_fault;
		end else if (alert_clear) begin
			rx_upper_mode_alert <= 1'b0;
			rx_lower_mode_alert <= 1'b0;
		end
	end

	dsff_osc_check #(
		.EXPECT_CNT(OSC_EXPECT_CNT),
		.CNT_W(16)
	) u_osc (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.slow_osc_tick(slow_osc_tick),
		.osc_fault(osc_fault)
	);

	// both oscillator alerts, sticky, set beats clear
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			slow_osc_alert_a <= 1'b0;
			slow_osc_alert_b <= 1'b0;
		end else if (osc_fault) begin
			slow_osc_alert_a <= 1'b1;
			slow_osc_alert_b <= 1'b1;
		end else if (alert_clear) begin
			slow_osc_alert_a <= 1'b0;
			slow_osc_alert_b <= 1'b0;
		end
	end

endmodule

// ==== dv/dsff_chk.sv ====
`timescale 1ns/1ps
module dsff_chk (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic conv_req,
	input wire logic conv_done,
	input wire logic [3:0] conv_source,
	input wire logic [13:0] conv_data,
	input wire logic [15:0] diag_result_a,
	input wire logic [15:0] diag_result_b,
	input wire logic dac_drive_en,
	input wire logic [13:0] dac_drive_code,
	input wire logic conv_force_zero,
	input wire logic conv_force_full,
	input wire logic measuring,
	input wire logic headroom_low_cmp,
	input wire logic pump_headroom_alert,
	input wire logic acq_done,
	input wire logic oversample_en,
	input wire logic acc_over_cmp,
	input wire logic accuracy_over_alert,
	input wire logic slow_osc_alert_a,
	input wire logic slow_osc_alert_b
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	AST_RESULT: assert property (conv_req && conv_done |=>
		diag_result_a == {$past(conv_data), 2'h0} ||
		diag_result_b == {$past(conv_data), 2'h0})
		else $error("result not loaded from conversion");
	AST_SRC: assert property (conv_req |-> conv_source inside {[1:13]})
		else $error("request for unassigned code");
	AST_DAC_HI: assert property (conv_req && conv_source == 4'h7 |->
		dac_drive_en && dac_drive_code == 14'h3000)
		else $error("dac not at three quarter scale");
	AST_DAC_LO: assert property (conv_req && conv_source == 4'h8 |->
		dac_drive_en && dac_drive_code == 14'h1000)
		else $error("dac not at one quarter scale");
	AST_ZERO: assert property (conv_req && conv_source == 4'ha |->
		conv_force_zero && !conv_force_full)
		else $error("zero scale input missing");
	AST_FULL: assert property (conv_req && conv_source == 4'hb |->
		conv_force_full && !conv_force_zero)
		else $error("full scale input missing");
	AST_HDRM: assert property (1'b1 |=> pump_headroom_alert ==
		($past(measuring) ? $past(headroom_low_cmp) :
		$past(pump_headroom_alert)))
		else $error("headroom alert wrong");
	AST_ACC: assert property (acq_done && oversample_en |=>
		accuracy_over_alert == $past(acc_over_cmp))
		else $error("accuracy over alert not loaded");
	AST_OSC: assert property (slow_osc_alert_a == slow_osc_alert_b)
		else $error("oscillator alerts differ");
endmodule

// ==== dv/tb_dsff_diag_ctl.sv ====
`timescale 1ns/1ps
module tb_dsff_diag_ctl;
	logic core_clk, reset_n, acq_start, acq_done, oversample_en, conv_done;
	logic scan_done, acc_over_cmp, acc_under_cmp, measuring, alert_clear;
	logic headroom_low_cmp, flex_pack_en, flex_fault_det, slow_osc_tick;
	logic rx_upper_fault, rx_lower_fault, conv_req, conv_ref_analog;
	logic [3:0] diag_select_a, diag_select_b, conv_source;
	logic [13:0] conv_data, dac_drive_code, switch_fault;
	logic [13:0] balance_switch_alert;
	logic [2:0] scan_config;
	logic [15:0] diag_result_a, diag_result_b, exp_a, exp_b;
	logic conv_force_zero, conv_force_full, dac_drive_en, diag_busy;
	logic thermistor_bias_en, temp_monitor_hold, accuracy_over_alert;
	logic balance_switch_alert_summary, accuracy_under_alert;
	logic pump_headroom_alert, flex_pack_fault_alert, rx_upper_mode_alert;
	logic rx_lower_mode_alert, slow_osc_alert_a, slow_osc_alert_b;
	int error_cnt, checks_done;
	dsff_diag_ctl #(
		.OSC_EXPECT_CNT(100)
	) dut_u (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.diag_select_a(diag_select_a),
		.diag_select_b(diag_select_b),
		.acq_start(acq_start),
		.acq_done(acq_done),
		.oversample_en(oversample_en),
		.conv_req(conv_req),
		.conv_source(conv_source),
		.conv_ref_analog(conv_ref_analog),
		.conv_force_zero(conv_force_zero),
		.conv_force_full(conv_force_full),
		.dac_drive_en(dac_drive_en),
		.dac_drive_code(dac_drive_code),
		.thermistor_bias_en(thermistor_bias_en),
		.temp_monitor_hold(temp_monitor_hold),
		.conv_done(conv_done),
		.conv_data(conv_data),
		.diag_result_a(diag_result_a),
		.diag_result_b(diag_result_b),
		.diag_busy(diag_busy),
		.scan_config(scan_config),
		.scan_done(scan_done),
		.switch_fault(switch_fault),
		.balance_switch_alert(balance_switch_alert),
		.balance_switch_alert_summary(balance_switch_alert_summary),
		.acc_over_cmp(acc_over_cmp),
		.acc_under_cmp(acc_under_cmp),
		.accuracy_over_alert(accuracy_over_alert),
		.accuracy_under_alert(accuracy_under_alert),
		.measuring(measuring),
		.headroom_low_cmp(headroom_low_cmp),
		.pump_headroom_alert(pump_headroom_alert),
		.flex_pack_en(flex_pack_en),
		.flex_fault_det(flex_fault_det),
		.flex_pack_fault_alert(flex_pack_fault_alert),
		.rx_upper_fault(rx_upper_fault),
		.rx_lower_fault(rx_lower_fault),
		.rx_upper_mode_alert(rx_upper_mode_alert),
		.rx_lower_mode_alert(rx_lower_mode_alert),
		.slow_osc_tick(slow_osc_tick),
		.slow_osc_alert_a(slow_osc_alert_a),
		.slow_osc_alert_b(slow_osc_alert_b),
		.alert_clear(alert_clear)
	);
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	task automatic print_verdict();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic cmp_res(input logic [15:0] exp, got);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask
	task automatic cmp_bit(input logic exp, got);
		cmp_res({15'h0, exp}, {15'h0, got});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
		cyc(1);
	endtask
	task automatic wait_until(input logic busy_sel, want);
		int n;
		n = 0;
		while ((busy_sel ? diag_busy : conv_req) !== want && n < 40) begin
			cyc(1);
			n++;
		end
		if ((busy_sel ? diag_busy : conv_req) !== want) begin
			cmp_bit(want, busy_sel ? diag_busy : conv_req);
			print_verdict();
		end
	endtask
	task automatic do_reset(input logic up, lo);
		reset_n = 1'b0;
		rx_upper_fault = up;
		rx_lower_fault = lo;
		cyc(20);
		reset_n = 1'b1;
		cyc(2);
		rx_upper_fault = 1'b0;
		rx_lower_fault = 1'b0;
		cmp_bit(up, rx_upper_mode_alert);
		cmp_bit(lo, rx_lower_mode_alert);
		exp_a = 16'h0;
		exp_b = 16'h0;
		cmp_res(exp_a, diag_result_a);
		cmp_res(exp_b, diag_result_b);
	endtask
	task automatic run_acq(input logic [3:0] sa, sb);
		logic [3:0] src;
		logic [13:0] d;
		diag_select_a = sa;
		diag_select_b = sb;
		pulse(acq_start);
		for (int k = 0; k < 2; k++) begin
			src = k ? sb : sa;
			d = {sa ^ sb, src, k ? 6'h15 : 6'h2a};
			if (src != 4'h0 && src < 4'he) begin
				wait_until(1'b0, 1'b1);
				cmp_res({12'h0, src},
					{12'h0, conv_source});
				cmp_bit(src == 4'h2, conv_ref_analog);
				cmp_bit(src == 4'h9, thermistor_bias_en);
				cmp_bit(src == 4'ha, conv_force_zero);
				cmp_bit(src == 4'hb, conv_force_full);
				cmp_bit(sa == 4'h1 || sb == 4'h1,
					temp_monitor_hold);
				cmp_bit(src == 4'h7 || src == 4'h8,
					dac_drive_en);
				if (src == 4'h7 || src == 4'h8)
					cmp_res({2'h0, src == 4'h7 ? 14'h3000 : 14'h1000},
						{2'h0, dac_drive_code});
				conv_data = d;
				pulse(conv_done);
				if (k == 1)
					exp_b = {d, 2'h0};
				else
					exp_a = {d, 2'h0};
			end
		end
		pulse(acq_done);
		wait_until(1'b1, 1'b0);
		cmp_res(exp_a, diag_result_a);
		cmp_res(exp_b, diag_result_b);
	endtask
	task automatic ticks(input int p, n);
		repeat (n) begin
			cyc(p - 2);
			pulse(slow_osc_tick);
		end
	endtask
	task automatic sc_osc();
		ticks(50, 6);
		cmp_bit(1'b0, slow_osc_alert_a);
		cmp_bit(1'b0, slow_osc_alert_b);
		ticks(60, 4);
		cmp_bit(1'b1, slow_osc_alert_a);
		cmp_bit(1'b1, slow_osc_alert_b);
	endtask
	task automatic sc_scan();
		logic [13:0] e;
		e = 14'h0;
		for (int c = 0; c < 8; c++) begin
			scan_config = c[2:0];
			switch_fault = 14'h0003 << c;
			pulse(scan_done);
			if (c > 3)
				e = e | switch_fault;
			cmp_res({2'h0, e}, {2'h0, balance_switch_alert});
			cmp_bit(e != 14'h0, balance_switch_alert_summary);
		end
		pulse(alert_clear);
		cmp_res(16'h0, {2'h0, balance_switch_alert});
		cmp_bit(1'b0, balance_switch_alert_summary);
		scan_config = 3'h4;
		switch_fault = 14'h0001;
		{scan_done, alert_clear} = 2'b11;
		cyc(1);
		{scan_done, alert_clear} = 2'b00;
		cyc(1);
		cmp_res(16'h0001, {2'h0, balance_switch_alert});
		cmp_bit(1'b1, balance_switch_alert_summary);
	endtask
	task automatic sc_acc();
		for (int j = 0; j < 4; j++) begin
			oversample_en = (j != 2);
			acc_over_cmp = j[0];
			acc_under_cmp = ~j[0];
			pulse(acq_done);
			cmp_bit(j[0] | (j == 2), accuracy_over_alert);
			cmp_bit(j == 0, accuracy_under_alert);
		end
	endtask
	task automatic sc_hdrm();
		for (int j = 0; j < 4; j++) begin
			measuring = j[0];
			headroom_low_cmp = ~j[1];
			cyc(2);
			cmp_bit(j == 1 || j == 2, pump_headroom_alert);
		end
	endtask
	task automatic sc_flex();
		flex_fault_det = 1'b1;
		cyc(2);
		cmp_bit(1'b0, flex_pack_fault_alert);
		flex_pack_en = 1'b1;
		cyc(2);
		flex_fault_det = 1'b0;
		cyc(2);
		cmp_bit(1'b1, flex_pack_fault_alert);
		pulse(alert_clear);
		cmp_bit(1'b0, flex_pack_fault_alert);
		{flex_fault_det, alert_clear} = 2'b11;
		cyc(1);
		{flex_fault_det, alert_clear} = 2'b00;
		cyc(1);
		cmp_bit(1'b1, flex_pack_fault_alert);
		pulse(alert_clear);
		cmp_bit(1'b0, flex_pack_fault_alert);
	endtask
	initial begin
		{acq_start, acq_done, oversample_en, conv_done, scan_done} = '0;
		{acc_over_cmp, acc_under_cmp, measuring, alert_clear} = '0;
		{headroom_low_cmp, flex_pack_en, flex_fault_det} = '0;
		{slow_osc_tick, diag_select_a, diag_select_b, conv_data} = '0;
		{switch_fault, scan_config} = '0;
		{rx_upper_fault, rx_lower_fault, reset_n} = '0;
		error_cnt = 0;
		checks_done = 0;
		do_reset(1'b1, 1'b0);
		sc_osc();
		for (int i = 0; i < 16; i++) begin
			run_acq(i[3:0], 4'hf - i[3:0]);
		end
		run_acq(4'h7, 4'h1);
		sc_scan();
		sc_acc();
		sc_hdrm();
		sc_flex();
		do_reset(1'b0, 1'b1);
		run_acq(4'h3, 4'hd);
		print_verdict();
	end
endmodule
bind dsff_diag_ctl dsff_chk chk_u (
	.core_clk(core_clk),
	.reset_n(reset_n),
	.conv_req(conv_req),
	.conv_done(conv_done),
	.conv_source(conv_source),
	.conv_data(conv_data),
	.diag_result_a(diag_result_a),
	.diag_result_b(diag_result_b),
	.dac_drive_en(dac_drive_en),
	.dac_drive_code(dac_drive_code),
	.conv_force_zero(conv_force_zero),
	.conv_force_full(conv_force_full),
	.measuring(measuring),
	.headroom_low_cmp(headroom_low_cmp),
	.pump_headroom_alert(pump_headroom_alert),
	.acq_done(acq_done),
	.oversample_en(oversample_en),
	.acc_over_cmp(acc_over_cmp),
	.accuracy_over_alert(accuracy_over_alert),
	.slow_osc_alert_a(slow_osc_alert_a),
	.slow_osc_alert_b(slow_osc_alert_b)
);
